// [design/gpio_alt_function_mux.sv]
// Lower pin bank mux: alternate functions, boot lane straps, park input.
// Assumes pads are resolved outside; all inputs synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module gpio_alt_function_mux #(
	parameter int SETTLE_CYCLES = gpio_mux_pkg::STRAP_SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Software configuration
	input wire gpio_mux_pkg::pin_cfg_s [11:0] pin_cfg,
	input wire logic [11:0] gpio_out_val,
	input wire logic [11:0] gpio_out_dir,
	// Aux serial engine
	input wire logic aux_serial_clock,
	input wire logic aux_serial_out,
	input wire logic aux_select0_n,
	input wire logic aux_select1_n,
	output logic aux_serial_in,
	// Thermistor and glasses sources
	input wire logic thermistor_power_en,
	input wire logic thermistor_charge_drive,
	input wire logic shutter_left,
	// Pads
	input wire logic [11:0] pad_in,
	output logic [11:0] pad_out,
	output logic [11:0] pad_oe,
	// Status
	output logic [11:0] gpio_in_val,
	output logic mirror_park,
	output logic strap_done,
	output logic [2:0] lane_count
);

	// ========================================
	// Elaboration check
	if (SETTLE_CYCLES < 1) begin : g_bad_settle
		$error("SETTLE_CYCLES must be at least one");
	end
	if (SETTLE_CYCLES > 65535) begin : g_big_settle
		$error("SETTLE_CYCLES must fit the settle counter");
	end

	gpio_mux_pkg::boot_state_e boot_state;
	gpio_mux_pkg::boot_state_e next_boot_state;
	logic [15:0] settle_cnt;
	logic [11:0] alt_a_ok;
	logic [11:0] alt_b_ok;
	logic [11:0] alt_val;
	logic [11:0] alt_oe;
	logic [11:0] use_alt;
	logic [11:0] force_in;
	logic booting;

	assign booting = (boot_state != gpio_mux_pkg::BOOT_RUN);

	// ========================================
	// Boot sequencer
	always_comb begin
		next_boot_state = boot_state;
		case (boot_state)
			gpio_mux_pkg::BOOT_IDLE: begin
				next_boot_state = gpio_mux_pkg::BOOT_SETTLE;
			end
			gpio_mux_pkg::BOOT_SETTLE: begin
				if (settle_cnt == 16'(SETTLE_CYCLES - 1)) begin
					next_boot_state = gpio_mux_pkg::BOOT_RUN;
				end
			end
			gpio_mux_pkg::BOOT_RUN: begin
				next_boot_state = gpio_mux_pkg::BOOT_RUN;
			end
			default: begin
				next_boot_state = gpio_mux_pkg::BOOT_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			boot_state <= gpio_mux_pkg::BOOT_IDLE;
		end else begin
			boot_state <= next_boot_state;
		end
	end

	// Settle counter for strap resistors
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			settle_cnt <= 16'h0000;
		end else if (boot_state == gpio_mux_pkg::BOOT_SETTLE) begin
			settle_cnt <= settle_cnt + 16'h0001;
		end
	end

	// ========================================
	// Strap capture, once per boot
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lane_count <= gpio_mux_pkg::LANES_RESET;
			strap_done <= 1'b0;
		end else if (boot_state == gpio_mux_pkg::BOOT_SETTLE &&
				next_boot_state == gpio_mux_pkg::BOOT_RUN) begin
			lane_count <= {1'b0, pad_in[2], pad_in[1]} + 3'h1;
			strap_done <= 1'b1;
		end
	end

	// ========================================
	// Alternate function table
	always_comb begin
		alt_a_ok = 12'h000;
		alt_b_ok = 12'h000;
		alt_val = 12'h000;
		alt_oe = 12'h000;
		// Aux serial data in, receive only
		alt_a_ok[gpio_mux_pkg::PIN_SER_IN] = 1'b1;
		// Aux serial clock out
		alt_a_ok[gpio_mux_pkg::PIN_SER_CLK] = 1'b1;
		alt_val[gpio_mux_pkg::PIN_SER_CLK] = aux_serial_clock;
		alt_oe[gpio_mux_pkg::PIN_SER_CLK] = 1'b1;
		// Aux serial data out
		alt_a_ok[gpio_mux_pkg::PIN_SER_OUT] = 1'b1;
		alt_val[gpio_mux_pkg::PIN_SER_OUT] = aux_serial_out;
		alt_oe[gpio_mux_pkg::PIN_SER_OUT] = 1'b1;
		// First chip select
		alt_a_ok[gpio_mux_pkg::PIN_SEL0] = 1'b1;
		alt_val[gpio_mux_pkg::PIN_SEL0] = aux_select0_n;
		alt_oe[gpio_mux_pkg::PIN_SEL0] = 1'b1;
		// Glasses shutter or second chip select
		alt_a_ok[gpio_mux_pkg::PIN_GLASSES] = 1'b1;
		alt_b_ok[gpio_mux_pkg::PIN_GLASSES] = 1'b1;
		alt_oe[gpio_mux_pkg::PIN_GLASSES] = 1'b1;
		if (pin_cfg[gpio_mux_pkg::PIN_GLASSES].func ==
				gpio_mux_pkg::FUNC_ALT_B) begin
			alt_val[gpio_mux_pkg::PIN_GLASSES] = aux_select1_n;
		end else begin
			alt_val[gpio_mux_pkg::PIN_GLASSES] = shutter_left;
		end
		// Park request, input only
		alt_a_ok[gpio_mux_pkg::PIN_PARK] = 1'b1;
		// Thermistor charge drive
		alt_a_ok[gpio_mux_pkg::PIN_CHARGE] = 1'b1;
		alt_val[gpio_mux_pkg::PIN_CHARGE] = thermistor_charge_drive;
		alt_oe[gpio_mux_pkg::PIN_CHARGE] = 1'b1;
		// Thermistor power enable
		alt_a_ok[gpio_mux_pkg::PIN_THERM] = 1'b1;
		alt_val[gpio_mux_pkg::PIN_THERM] = thermistor_power_en;
		alt_oe[gpio_mux_pkg::PIN_THERM] = 1'b1;
	end

	// ========================================
	// Function selection and pin cells
	for (genvar i = 0; i < gpio_mux_pkg::NUM_PINS; i++) begin : g_pin
		// Unavailable selects fall back to general-purpose use
		assign use_alt[i] =
			(pin_cfg[i].func == gpio_mux_pkg::FUNC_ALT_A && alt_a_ok[i]) ||
			(pin_cfg[i].func == gpio_mux_pkg::FUNC_ALT_B && alt_b_ok[i]);
		// Strap pins float while booting
		if (i == gpio_mux_pkg::PIN_SER_CLK ||
				i == gpio_mux_pkg::PIN_SER_OUT) begin : g_strap
			assign force_in[i] = booting;
		end else begin : g_plain
			assign force_in[i] = 1'b0;
		end
		gpio_pin_cell u_cell (
			.mclk(mclk),
			.rst(rst),
			.mode(pin_cfg[i].mode),
			.use_alt(use_alt[i]),
			.force_in(force_in[i]),
			.gpio_val(gpio_out_val[i]),
			.gpio_dir(gpio_out_dir[i]),
			.alt_val(alt_val[i]),
			.alt_oe(alt_oe[i]),
			.pad_out(pad_out[i]),
			.pad_oe(pad_oe[i])
		);
	end

	// ========================================
	// Input capture and park request
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gpio_in_val <= 12'h000;
			aux_serial_in <= 1'b1;
			mirror_park <= 1'b0;
		end else begin
			gpio_in_val <= pad_in;
			aux_serial_in <= use_alt[gpio_mux_pkg::PIN_SER_IN] ?
				pad_in[gpio_mux_pkg::PIN_SER_IN] : 1'b1;
			// Park only, no power-down path; honoured after boot
			mirror_park <= ~booting &&
				use_alt[gpio_mux_pkg::PIN_PARK] &&
				~pad_in[gpio_mux_pkg::PIN_PARK];
		end
	end

	// ========================================
	// Checks
	chk_park_follows_pin: assert property (
		@(posedge mclk) disable iff (rst)
		(~booting && use_alt[8] && ~pad_in[8]) |=> mirror_park)
		else $error("park request not honoured");

	chk_shutter_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(pin_cfg[4].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[4] && pad_out[4] == $past(shutter_left)))
		else $error("shutter output wrong");

	chk_select1_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(pin_cfg[4].func == gpio_mux_pkg::FUNC_ALT_B)
		|=> (pad_oe[4] && pad_out[4] == $past(aux_select1_n)))
		else $error("second select wrong");

	chk_select0_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(pin_cfg[3].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[3] && pad_out[3] == $past(aux_select0_n)))
		else $error("first select wrong");

	chk_clock_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(~booting && pin_cfg[1].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[1] && pad_out[1] == $past(aux_serial_clock)))
		else $error("serial clock wrong");

	chk_data_out_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(~booting && pin_cfg[2].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[2] && pad_out[2] == $past(aux_serial_out)))
		else $error("serial data out wrong");

	chk_strap_float: assert property (
		@(posedge mclk) disable iff (rst)
		booting |=> (~pad_oe[1] && ~pad_oe[2]))
		else $error("strap pin driven during boot");

	chk_lane_code: assert property (
		@(posedge mclk) disable iff (rst)
		$rose(strap_done)
		|-> lane_count == {1'b0, $past(pad_in[2]), $past(pad_in[1])} + 3'h1)
		else $error("lane count decode wrong");

	chk_strap_hold: assert property (
		@(posedge mclk) disable iff (rst)
		strap_done |=> (strap_done && $stable(lane_count)))
		else $error("lane strap changed after boot");

	chk_open_drain: assert property (
		@(posedge mclk) disable iff (rst)
		(~use_alt[5] && pin_cfg[5].mode == gpio_mux_pkg::MODE_OPEN_DRAIN)
		|=> (~pad_out[5] && pad_oe[5] == ~$past(gpio_out_val[5])))
		else $error("open drain drive wrong");

	chk_therm_power: assert property (
		@(posedge mclk) disable iff (rst)
		(pin_cfg[11].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[11] && pad_out[11] == $past(thermistor_power_en)))
		else $error("thermistor power wrong");

	chk_charge_drive: assert property (
		@(posedge mclk) disable iff (rst)
		(pin_cfg[10].func == gpio_mux_pkg::FUNC_ALT_A)
		|=> (pad_oe[10] && pad_out[10] == $past(thermistor_charge_drive)))
		else $error("charge drive wrong");

	chk_park_release: assert property (
		@(posedge mclk) disable iff (rst)
		pad_in[8] |=> ~mirror_park)
		else $error("park without request");

	chk_park_boot: assert property (
		@(posedge mclk) disable iff (rst)
		booting |=> ~mirror_park)
		else $error("park honoured during boot");

	chk_serial_in_float: assert property (
		@(posedge mclk) disable iff (rst)
		use_alt[0] |=> ~pad_oe[0])
		else $error("serial input pin driven");

	chk_serial_in_value: assert property (
		@(posedge mclk) disable iff (rst)
		use_alt[0] |=> (aux_serial_in == $past(pad_in[0])))
		else $error("serial input not passed on");

	chk_lane_before_strap: assert property (
		@(posedge mclk) disable iff (rst)
		~strap_done |-> (lane_count == gpio_mux_pkg::LANES_RESET))
		else $error("lane count moved before strap");

	cov_boot_done: cover property (
		@(posedge mclk) disable iff (rst) $rose(strap_done));
	cov_four_lanes: cover property (
		@(posedge mclk) disable iff (rst) strap_done && lane_count == 3'h4);
	cov_park: cover property (
		@(posedge mclk) disable iff (rst) $rose(mirror_park));
	cov_select1: cover property (
		@(posedge mclk) disable iff (rst)
		pin_cfg[4].func == gpio_mux_pkg::FUNC_ALT_B && ~pad_out[4]);

endmodule // gpio_alt_function_mux

`default_nettype wire

// [design/gpio_mux_pkg.sv]
// Shared constants and carriers for the lower general-purpose pin bank.
// Assumes one core clock and an active-high asynchronous reset.
//
// Contract
// - Low parking request parks the mirror array; never powers it down. The design ignores it until boot ends.
// - Pin 04 glasses function: one selects left eye, zero right eye.
// - Pin 04 may act as second active-low aux chip select.
// - Pin 03 acts as first active-low aux chip select.
// - Pin 01 drives the aux serial clock.
// - Pin 02 drives the aux serial data out.
// - Pin 00 receives the aux serial data in.
// - During boot, pins 01 and 02 are sampled as lane straps.
// - Strap code pin02:pin01 gives lanes 00=1, 01=2, 10=3, 11=4.
// - After strap sampling pins 01 and 02 resume serial outputs.
// - Each pin configurable as input, output, bidirectional or open-drain.
// - Software selects general-purpose use or each alternate use.
// - Pin 11 thermistor option drives thermistor power enable.
// - Pin 10 alternate option drives the thermistor charge network.

package gpio_mux_pkg;

	// ========================================
	// Bank geometry and pin roles
	localparam int NUM_PINS = 12;
	localparam int PIN_SER_IN = 0;
	localparam int PIN_SER_CLK = 1;
	localparam int PIN_SER_OUT = 2;
	localparam int PIN_SEL0 = 3;
	localparam int PIN_GLASSES = 4;
	localparam int PIN_PARK = 8;
	localparam int PIN_CHARGE = 10;
	localparam int PIN_THERM = 11;

	// ========================================
	// Pin electrical modes
	localparam logic [1:0] MODE_INPUT = 2'h0;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam logic [1:0] MODE_BIDIR = 2'h2;
	localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

	// ========================================
	// Pin function selects
	localparam logic [1:0] FUNC_GPIO = 2'h0;
	localparam logic [1:0] FUNC_ALT_A = 2'h1;
	localparam logic [1:0] FUNC_ALT_B = 2'h2;

	// ========================================
	// Strap timing and reset values
	localparam int CLK_PERIOD_NS = 50;
	localparam int STRAP_SETTLE_NS = 1000;
	localparam int STRAP_SETTLE_CYC =
		(STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] STRAP_RESET = 2'h0;
	localparam logic [2:0] LANES_RESET = 3'h1;

	// Per-pin configuration from software
	typedef struct packed {
		logic [1:0] func;
		logic [1:0] mode;
	} pin_cfg_s;

	// Boot sequencing
	typedef enum logic [1:0] {
		BOOT_IDLE = 2'b00,
		BOOT_SETTLE = 2'b01,
		BOOT_RUN = 2'b10
	} boot_state_e;

endpackage

// [design/gpio_pin_cell.sv]
// One pad driver: resolves mode and function into registered drive.
// Assumes pad input is synchronous to mclk; enable high means driving.
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Configuration
	input wire logic [1:0] mode,
	input wire logic use_alt,
	input wire logic force_in,
	// Drive sources
	input wire logic gpio_val,
	input wire logic gpio_dir,
	input wire logic alt_val,
	input wire logic alt_oe,
	// Pad side
	output logic pad_out,
	output logic pad_oe
);

	logic next_out;
	logic next_oe;

	// ========================================
	// Drive resolution
	always_comb begin
		next_out = 1'b0;
		next_oe = 1'b0;
		if (force_in) begin
			next_oe = 1'b0;
		end else if (use_alt) begin
			next_out = alt_val;
			next_oe = alt_oe;
		end else begin
			case (mode)
				gpio_mux_pkg::MODE_INPUT: begin
					next_oe = 1'b0;
				end
				gpio_mux_pkg::MODE_OUTPUT: begin
					next_out = gpio_val;
					next_oe = 1'b1;
				end
				gpio_mux_pkg::MODE_BIDIR: begin
					next_out = gpio_val;
					next_oe = gpio_dir;
				end
				gpio_mux_pkg::MODE_OPEN_DRAIN: begin
					next_out = 1'b0;
					next_oe = ~gpio_val;
				end
				default: begin
					next_oe = 1'b0;
				end
			endcase
		end
	end

	// Registered pad drive
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_out <= 1'b0;
			pad_oe <= 1'b0;
		end else begin
			pad_out <= next_out;
			pad_oe <= next_oe;
		end
	end

endmodule // gpio_pin_cell

`default_nettype wire

// [testbench/gpio_alt_function_mux_tb_top.sv]
// Testbench for the lower pin bank mux: straps, alternates, modes, park.
// Assumes the far-side model and a shortened strap settle count.
`timescale 1ns/1ps
`default_nettype none

module gpio_alt_function_mux_tb_top;
	localparam int SETTLE = 2;
	logic mclk, rst;
	gpio_mux_pkg::pin_cfg_s [11:0] pin_cfg;
	logic [11:0] gpio_out_val, gpio_out_dir, ext_level, pad_in;
	logic [11:0] pad_out, pad_oe, gpio_in_val;
	logic aux_serial_clock, aux_serial_out, aux_select0_n, aux_select1_n;
	logic aux_serial_in, thermistor_power_en, thermistor_charge_drive;
	logic shutter_left, mirror_park, strap_done, host_park_n, pmic_dout;
	logic [2:0] lane_count;
	logic [6:0] tab [7];
	int err_count, checks_done;

	// ========================================
	// Clock, design and far side
	always #25 mclk = ~mclk;

	gpio_alt_function_mux #(.SETTLE_CYCLES(SETTLE)) dut_u (
		.mclk(mclk), .rst(rst), .pin_cfg(pin_cfg),
		.gpio_out_val(gpio_out_val), .gpio_out_dir(gpio_out_dir),
		.aux_serial_clock(aux_serial_clock), .aux_serial_out(aux_serial_out),
		.aux_select0_n(aux_select0_n), .aux_select1_n(aux_select1_n),
		.aux_serial_in(aux_serial_in),
		.thermistor_power_en(thermistor_power_en),
		.thermistor_charge_drive(thermistor_charge_drive),
		.shutter_left(shutter_left), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .gpio_in_val(gpio_in_val), .mirror_park(mirror_park),
		.strap_done(strap_done), .lane_count(lane_count));

	gpio_far_side_model far_u (
		.mclk(mclk), .rst(rst), .pad_out(pad_out), .pad_oe(pad_oe),
		.strap_done(strap_done), .ext_level(ext_level),
		.host_park_n(host_park_n), .pmic_dout(pmic_dout), .pad_in(pad_in));

	// ========================================
	// Shared tasks
	task automatic check(input string what, input logic [11:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task automatic set_pin(input int p, input logic [1:0] f, m);
		@(posedge mclk);
		pin_cfg[p] <= {f, m};
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Reset, then follow the strap phase edge by edge
	task automatic boot(input logic [1:0] strap);
		@(posedge mclk);
		rst <= 1'b1;
		ext_level[2:1] <= strap;
		repeat (3) @(posedge mclk);
		#1;
		check("oe in reset", pad_oe, 12'h000);
		check("lanes in reset", {9'h0, lane_count}, 12'h001);
		check("park in reset", {11'h0, mirror_park}, 12'h000);
		check("serial in reset", {11'h0, aux_serial_in}, 12'h001);
		@(posedge mclk);
		rst <= 1'b0;
		repeat (SETTLE) @(posedge mclk);
		#1;
		check("strap early", {11'h0, strap_done}, 12'h000);
		check("strap pins oe", {10'h0, pad_oe[2:1]}, 12'h000);
		@(posedge mclk);
		#1;
		check("strap done", {11'h0, strap_done}, 12'h001);
		check("lanes", {9'h0, lane_count}, {10'h0, strap} + 12'h1);
	endtask

	// Hang guard
	initial begin
		#500000;
		err_count++;
		complete_run();
	end

	// ========================================
	// Main sequence
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		// Unused pins as outputs driving zero
		pin_cfg = {12{gpio_mux_pkg::FUNC_GPIO,
			gpio_mux_pkg::MODE_OUTPUT}};
		gpio_out_val = 12'h000;
		gpio_out_dir = 12'h000;
		ext_level = 12'hfff;
		{aux_serial_clock, aux_serial_out, thermistor_power_en} = 3'h0;
		{thermistor_charge_drive, shutter_left, pmic_dout} = 3'h0;
		{aux_select0_n, aux_select1_n, host_park_n} = 3'h7;
		err_count = 0;
		checks_done = 0;
		for (int s = 0; s < 4; s++) begin
			boot(s[1:0]);
		end
		$display("test straps finished");

		// Serial port pins, and strap pins moving after boot
		set_pin(1, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_OUTPUT);
		set_pin(2, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_OUTPUT);
		set_pin(3, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_OUTPUT);
		set_pin(0, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_INPUT);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			aux_serial_clock <= !i[0];
			aux_serial_out <= i[0];
			aux_select0_n <= 1'b0;
			pmic_dout <= !i[0];
			ext_level[2:1] <= i[1:0];
			settle();
			check("serial clock", {11'h0, pad_out[1]}, {11'h0, !i[0]});
			check("serial data", {11'h0, pad_out[2]}, {11'h0, i[0]});
			check("select0", {11'h0, pad_out[3]}, 12'h000);
			check("serial oe", {9'h0, pad_oe[3:1]}, 12'h7);
			check("serial in", {11'h0, aux_serial_in}, {11'h0, !i[0]});
			check("lanes held", {9'h0, lane_count}, 12'h004);
		end
		$display("test serial finished");

		// Park request from the host
		set_pin(8, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_INPUT);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			host_park_n <= i[0];
			settle();
			check("park", {11'h0, mirror_park}, {11'h0, !i[0]});
			check("park oe", {11'h0, pad_oe[8]}, 12'h000);
		end
		$display("test park finished");

		// Pin 04 glasses shutter, then second select
		for (int i = 0; i < 4; i++) begin
			set_pin(4, i < 2 ? gpio_mux_pkg::FUNC_ALT_A : gpio_mux_pkg::FUNC_ALT_B,
				gpio_mux_pkg::MODE_OUTPUT);
			shutter_left <= i[0];
			aux_select1_n <= !i[0];
			settle();
			check("pin4 oe", {11'h0, pad_oe[4]}, 12'h001);
			check("pin4", {11'h0, pad_out[4]}, {11'h0, i[0] ^ (i > 1)});
		end
		$display("test pin4 finished");

		// Thermistor alternates against plain use
		set_pin(10, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_OUTPUT);
		set_pin(11, gpio_mux_pkg::FUNC_ALT_A, gpio_mux_pkg::MODE_OUTPUT);
		thermistor_power_en <= 1'b1;
		gpio_out_val[11:10] <= 2'h1;
		settle();
		check("therm oe", {10'h0, pad_oe[11:10]}, 12'h003);
		check("therm pads", {10'h0, pad_out[11:10]}, 12'h002);
		set_pin(10, gpio_mux_pkg::FUNC_GPIO, gpio_mux_pkg::MODE_OUTPUT);
		set_pin(11, gpio_mux_pkg::FUNC_GPIO, gpio_mux_pkg::MODE_OUTPUT);
		settle();
		check("gpio oe", {10'h0, pad_oe[11:10]}, 12'h003);
		check("gpio pads", {10'h0, pad_out[11:10]}, 12'h001);
		// Unavailable alternate falls back to plain output
		set_pin(9, gpio_mux_pkg::FUNC_ALT_B, gpio_mux_pkg::MODE_OUTPUT);
		gpio_out_val[9] <= 1'b1;
		settle();
		check("pin9 oe", {11'h0, pad_oe[9]}, 12'h001);
		check("pin9 pad", {11'h0, pad_out[9]}, 12'h001);
		$display("test thermistor finished");

		// Pin 05 modes: {mode, val, dir, far level, expected oe, expected in}
		tab = '{7'h33, 7'h26, 7'h18, 7'h5b, 7'h50, 7'h66, 7'h75};
		for (int i = 0; i < 7; i++) begin
			set_pin(5, gpio_mux_pkg::FUNC_GPIO, tab[i][6:5]);
			gpio_out_val[5] <= tab[i][4];
			gpio_out_dir[5] <= tab[i][3];
			ext_level[5] <= tab[i][2];
			settle();
			check("pin5 oe", {11'h0, pad_oe[5]}, {11'h0, tab[i][1]});
			check("pin5 in", {11'h0, gpio_in_val[5]}, {11'h0, tab[i][0]});
		end
		$display("test modes finished");
		complete_run();
	end
endmodule // gpio_alt_function_mux_tb_top

`default_nettype wire

// [testbench/gpio_far_side_model.sv]
// Far-side model: host park request, lane strap resistors, power chip.
// Assumes the bank's registered pad drive; undriven pads take far levels.
`timescale 1ns/1ps
`default_nettype none

module gpio_far_side_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Bank pads and boot status
	input wire logic [11:0] pad_out,
	input wire logic [11:0] pad_oe,
	input wire logic strap_done,
	// Far-side stimulus
	input wire logic [11:0] ext_level,
	input wire logic host_park_n,
	input wire logic pmic_dout,
	// Levels back to the bank
	output logic [11:0] pad_in
);
	logic filler;
	logic [11:0] far;

	// ========================================
	// Changing pattern on the released serial input
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			filler <= 1'b0;
		end else begin
			filler <= ~filler;
		end
	end

	// Power chip answers only when selected; park held high through boot
	always_comb begin
		far = ext_level;
		far[0] = (pad_oe[3] && !pad_out[3]) ? pmic_dout : filler;
		far[8] = strap_done ? host_park_n : 1'b1;
		pad_in = (pad_oe & pad_out) | (~pad_oe & far);
	end
endmodule // gpio_far_side_model

`default_nettype wire
